// ===== src/sbrp_pkg.sv
package sbrp_pkg;

    // ------------------------------------------------------------
    // register indices on the serial port
    // ------------------------------------------------------------
    localparam logic [7:0] IDX_PLL_MODE_SELECT = 8'h00;
    localparam logic [7:0] IDX_READBACK_COUNT  = 8'h07;

    // ------------------------------------------------------------
    // field positions of pll_mode_select
    // ------------------------------------------------------------
    localparam int POS_READBACK_HI  = 7;
    localparam int POS_READBACK_LO  = 6;
    localparam int POS_OVERRIDE     = 3;
    localparam int POS_MODE_HI      = 2;
    localparam int POS_MODE_LO      = 1;
    localparam int READBACK_CNT_W   = 5;

    // ------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------
    localparam logic       RST_OVERRIDE       = 1'b0;
    localparam logic [1:0] RST_SW_MODE        = 2'h3;
    localparam logic [1:0] RST_STRAP          = 2'h0;
    localparam logic [4:0] RST_READBACK_COUNT = 5'h08;
    localparam logic [1:0] RSV_BITS_5_4       = 2'h0;
    localparam logic       RSV_BIT_0          = 1'b1;

    // ------------------------------------------------------------
    // counts of cycles and bit positions
    // ------------------------------------------------------------
    localparam logic [1:0] STRAP_SETTLE_CYCLES = 2'h3;
    localparam logic [3:0] BITS_PER_BYTE       = 4'h8;
    localparam logic [3:0] ACK_SLOT_END        = 4'h9;

    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef struct packed {
        logic [1:0] strap;
        logic       sda;
        logic       scl;
    } sbrp_pins_t;

    typedef struct packed {
        logic       override;
        logic [1:0] sw_mode;
    } sbrp_cfg_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_INDEX,
        ST_COUNT,
        ST_WDATA,
        ST_TX_COUNT,
        ST_TX_DATA
    } sbrp_state_t;

endpackage

// ===== src/sbrp_sync.sv
`timescale 1ns/100ps

// three-stage pin filter: output follows once stages two and three agree
module sbrp_sync #(
    parameter int W = 1
) (
    // clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_rst,
    // pins in, filtered levels out
    input  wire logic [W-1:0] i_async,
    input  wire logic [W-1:0] i_rst_val,
    output logic      [W-1:0] o_level
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;
    logic [W-1:0] lvl_q;
    logic [W-1:0] lvl_d;

    // per bit, accept a change only when the two late stages agree
    assign lvl_d = (s2_q & s3_q) | (lvl_q & (s2_q | s3_q));

    // stage one is read by stage two only
    always_ff @(posedge i_clk) begin
        s1_q <= i_async;
        s2_q <= s1_q;
        s3_q <= s2_q;
        if (i_rst) begin
            lvl_q <= i_rst_val;
        end else begin
            lvl_q <= lvl_d;
        end
    end

    assign o_level = lvl_q;

endmodule // sbrp_sync

// ===== src/sbrp_top.sv
`timescale 1ns/100ps

module sbrp_top
    import sbrp_pkg::*;
#(
    parameter logic [6:0] SLAVE_ADDR = 7'h35   // arbitrary value
) (
    // clock and reset
    input  wire logic                   i_clk,
    input  wire logic                   i_rst,
    // serial management pins
    input  wire logic                   i_scl,
    input  wire logic                   i_sda,
    output logic                        o_sda_o,
    output logic                        o_sda_oe,
    // mode strap pin
    input  wire logic [1:0]             i_mode_strap,
    // pll mode towards the clock core
    output sbrp_pkg::sbrp_cfg_t         o_cfg,
    output logic [1:0]                  o_pll_mode,
    output logic                        o_strap_valid
);
    import sbrp_pkg::*;

    // ------------------------------------------------------------
    // pin filtering and edge detection
    // ------------------------------------------------------------
    sbrp_pins_t   pins;
    sbrp_pins_t   pins_prev_q;
    sbrp_pins_t   pins_rst;

    assign pins_rst = '{strap: RST_STRAP, sda: 1'b1, scl: 1'b1};

    sbrp_sync #(
        .W          (4)
    ) u_sync (
        .i_clk      (i_clk),
        .i_rst      (i_rst),
        .i_async    ({i_mode_strap, i_sda, i_scl}),
        .i_rst_val  (pins_rst),
        .o_level    (pins)
    );

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pins_prev_q <= pins_rst;
        end else begin
            pins_prev_q <= pins;
        end
    end

    // bus events on the filtered lines
    wire scl_rise = pins.scl & ~pins_prev_q.scl;
    wire scl_fall = ~pins.scl & pins_prev_q.scl;
    wire start_ev = pins.scl & pins_prev_q.scl & ~pins.sda & pins_prev_q.sda;
    wire stop_ev  = pins.scl & pins_prev_q.scl & pins.sda & ~pins_prev_q.sda;

    // ------------------------------------------------------------
    // strap latch after reset release
    // ------------------------------------------------------------
    logic [1:0] settle_q;
    logic       strap_valid_q;
    logic [1:0] strap_q;

    // wait for the filter to fill, then capture the strap once
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            settle_q      <= 2'h0;
            strap_valid_q <= 1'b0;
            strap_q       <= RST_STRAP;
        end else if (!strap_valid_q) begin
            settle_q <= settle_q + 2'h1;
            if (settle_q == STRAP_SETTLE_CYCLES) begin
                strap_valid_q <= 1'b1;
                strap_q       <= pins.strap;
            end
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    sbrp_cfg_t  cfg_q;
    logic [4:0] rb_count_q;
    logic [7:0] idx_q;
    logic [7:0] rd_byte;
    logic [7:0] mode_byte;

    // byte zero image: strap readback, fixed reserved bits, writable fields
    assign mode_byte = {strap_q, RSV_BITS_5_4, cfg_q.override,
                        cfg_q.sw_mode, RSV_BIT_0};

    // read selection by current index; unmapped indices read zero
    assign rd_byte = (idx_q == IDX_PLL_MODE_SELECT) ? mode_byte :
                     (idx_q == IDX_READBACK_COUNT)  ? {3'h0, rb_count_q} :
                     8'h00;

    // mode source selection; readback stays on the strap
    assign o_pll_mode    = cfg_q.override ? cfg_q.sw_mode : strap_q;
    assign o_cfg         = cfg_q;
    assign o_strap_valid = strap_valid_q;

    // ------------------------------------------------------------
    // serial protocol engine
    // ------------------------------------------------------------
    sbrp_state_t st_q;
    logic [3:0]  bit_q;
    logic [7:0]  sh_q;
    logic        oe_q;
    logic [7:0]  wcnt_q;

    wire [7:0] rx_byte  = sh_q;
    wire       addr_hit = (rx_byte[7:1] == SLAVE_ADDR);
    wire [7:0] tx_load  = (st_q == ST_TX_COUNT) ? {3'h0, rb_count_q} : rd_byte;
    wire       tx_st    = (st_q == ST_TX_COUNT) || (st_q == ST_TX_DATA);

    // bit handling: sample on scl rise, change sda on scl fall
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            st_q       <= ST_IDLE;
            bit_q      <= 4'h0;
            sh_q       <= 8'h00;
            oe_q       <= 1'b0;
            idx_q      <= 8'h00;
            wcnt_q     <= 8'h00;
            cfg_q      <= '{override: RST_OVERRIDE, sw_mode: RST_SW_MODE};
            rb_count_q <= RST_READBACK_COUNT;
        end else if (start_ev) begin
            st_q  <= ST_ADDR;        // start or repeated start
            bit_q <= 4'h0;
            oe_q  <= 1'b0;
        end else if (stop_ev) begin
            st_q  <= ST_IDLE;
            bit_q <= 4'h0;
            oe_q  <= 1'b0;
        end else if (st_q != ST_IDLE) begin
            if (scl_rise && bit_q < BITS_PER_BYTE) begin
                // while transmitting the shifter only moves on the falling edge
                if (!tx_st) begin
                    sh_q <= {sh_q[6:0], pins.sda};
                end
                bit_q <= bit_q + 4'h1;
            end else if (scl_rise && bit_q == BITS_PER_BYTE) begin
                // host answer to a transmitted byte
                if (pins.sda) begin
                    st_q <= ST_IDLE;  // not-acknowledge: wait for stop
                end else begin
                    bit_q <= ACK_SLOT_END;
                end
            end else if (scl_fall && bit_q < BITS_PER_BYTE &&
                         (st_q == ST_TX_COUNT || st_q == ST_TX_DATA) && bit_q != 4'h0) begin
                oe_q <= ~sh_q[7];
                sh_q <= {sh_q[6:0], 1'b0};
            end else if (scl_fall && bit_q == BITS_PER_BYTE) begin
                bit_q <= ACK_SLOT_END;
                oe_q  <= 1'b1;  // acknowledge the received byte
                case (st_q)
                    ST_ADDR: begin
                        if (!addr_hit) begin
                            st_q <= ST_IDLE;
                            oe_q <= 1'b0;
                        end else if (rx_byte[0]) begin
                            st_q <= ST_TX_COUNT;
                        end else begin
                            st_q <= ST_INDEX;
                        end
                    end
                    ST_INDEX: begin
                        idx_q <= rx_byte;
                        st_q  <= ST_COUNT;
                    end
                    ST_COUNT: begin
                        wcnt_q <= rx_byte;
                        st_q   <= ST_WDATA;
                    end
                    ST_WDATA: begin
                        // write the byte at the current index
                        if (idx_q == IDX_PLL_MODE_SELECT) begin
                            cfg_q.override <= rx_byte[POS_OVERRIDE];
                            cfg_q.sw_mode  <= rx_byte[POS_MODE_HI:POS_MODE_LO];
                        end else if (idx_q == IDX_READBACK_COUNT) begin
                            rb_count_q <= rx_byte[READBACK_CNT_W-1:0];
                        end
                        idx_q  <= idx_q + 8'h01;
                        wcnt_q <= wcnt_q - 8'h01;
                    end
                    default: begin
                        // transmit: release and wait for the host answer at bit eight
                        bit_q <= BITS_PER_BYTE;
                        oe_q  <= 1'b0;
                    end
                endcase
            end else if (scl_fall && bit_q == ACK_SLOT_END) begin
                bit_q <= 4'h0;
                if (st_q == ST_TX_COUNT || st_q == ST_TX_DATA) begin
                    // count goes first, then data from the index
                    oe_q <= ~tx_load[7];
                    sh_q <= {tx_load[6:0], 1'b0};
                    if (st_q == ST_TX_COUNT) begin
                        st_q <= ST_TX_DATA;
                    end else begin
                        idx_q <= idx_q + 8'h01;
                    end
                end else begin
                    oe_q <= 1'b0;
                end
            end
        end
    end

    // open-drain: only ever pull low
    assign o_sda_o  = 1'b0;
    assign o_sda_oe = oe_q;

endmodule // sbrp_top

// ===== test/sbrp_host.sv
`timescale 1ns/100ps
// ------------------------------
// host controller model
// ------------------------------
module sbrp_host (
    // clock
    input  wire logic i_clk,
    // data line level
    input  wire logic i_sda,
    // clock line and data pull-down
    output logic      o_scl,
    output logic      o_pull
);
    // bus idles released and high
    initial begin
        o_scl = 1'b1;
        o_pull = 1'b0;
    end
    // half bit of 12 cycles keeps both clock phases above 10
    task automatic half();
        repeat (12) @(posedge i_clk);
    endtask
    // start or repeated start: data falls while clock high
    task automatic start();
        o_pull <= 1'b0;
        half();
        o_scl <= 1'b1;
        half();
        o_pull <= 1'b1;
        half();
        o_scl <= 1'b0;
        half();
    endtask
    // stop: data rises while clock high
    task automatic stop();
        o_pull <= 1'b1;
        half();
        o_scl <= 1'b1;
        half();
        o_pull <= 1'b0;
        half();
    endtask
    // one bit; data moves only while clock low, sampled late in high phase
    task automatic bitx(input logic b, output logic r);
        o_pull <= ~b;
        half();
        o_scl <= 1'b1;
        half();
        r = i_sda;
        o_scl <= 1'b0;
        half();
    endtask
    // byte msb first, then the acknowledge slot: low acks, high ends a read
    task automatic xfer(input logic [7:0] d, input logic last,
                        output logic [7:0] q, output logic ack);
        for (int i = 7; i >= 0; i--)
            bitx(d[i], q[i]);
        bitx(last, ack);
    endtask
endmodule // sbrp_host

// ===== test/sbrp_top_properties.sv
`timescale 1ns/100ps
// ------------------------------
// pin checker
// ------------------------------
module sbrp_top_properties
    import sbrp_pkg::*;
(
    // clock and reset
    input wire logic                i_clk,
    input wire logic                i_rst,
    // watched pins
    input wire logic                i_scl,
    input wire logic                o_sda_oe,
    input wire sbrp_pkg::sbrp_cfg_t o_cfg,
    input wire logic [1:0]          o_pll_mode,
    input wire logic                o_strap_valid
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (i_rst);
    // values right after reset
    property p_rst_ovr; $fell(i_rst) |-> !o_cfg.override && !o_strap_valid; endproperty
    a_rst_ovr: assert property (p_rst_ovr) else $error("override set after reset");
    property p_rst_mode; $fell(i_rst) |-> o_cfg.sw_mode == RST_SW_MODE && !o_sda_oe; endproperty
    a_rst_mode: assert property (p_rst_mode) else $error("bad mode after reset");
    // strap latch is taken soon and then held
    property p_latch; $fell(i_rst) |-> ##[1:12] o_strap_valid; endproperty
    a_latch: assert property (p_latch) else $error("strap not latched");
    property p_keep; o_strap_valid |=> o_strap_valid; endproperty
    a_keep: assert property (p_keep) else $error("latch flag dropped");
    property p_hold; o_strap_valid && !o_cfg.override |=> o_cfg.override || $stable(o_pll_mode);
    endproperty
    a_hold: assert property (p_hold) else $error("mode moved with pin");
    // override picks the written mode bits
    property p_ovr; o_cfg.override |-> o_pll_mode == o_cfg.sw_mode; endproperty
    a_ovr: assert property (p_ovr) else $error("override ignored");
    // register and data line change only while the clock line is low
    property p_cfg_low; $changed(o_cfg) |-> !i_scl; endproperty
    a_cfg_low: assert property (p_cfg_low) else $error("write off clock low");
    property p_oe_low; $changed(o_sda_oe) |-> !i_scl; endproperty
    a_oe_low: assert property (p_oe_low) else $error("data moved, clock high");
    cover property ($rose(o_cfg.override));
    cover property ($rose(o_sda_oe));
    cover property ($rose(o_strap_valid));
endmodule // sbrp_top_properties

bind sbrp_top sbrp_top_properties chk (.i_clk(i_clk), .i_rst(i_rst), .i_scl(i_scl),
    .o_sda_oe(o_sda_oe), .o_cfg(o_cfg), .o_pll_mode(o_pll_mode), .o_strap_valid(o_strap_valid));

// ===== test/test_smbus_block_register_port.sv
`timescale 1ns/100ps
// ------------------------------
// bench for the serial register port
// ------------------------------
module test_smbus_block_register_port;
    import sbrp_pkg::*;
    localparam logic [6:0] ADDR = 7'h35; // arbitrary value
    logic       i_clk = 1'b0;
    logic       i_rst = 1'b1;
    logic [1:0] strap = 2'h2;
    wire        scl, pull, oe, sda_o;
    wire        sda = !(pull || (oe && !sda_o)); // open drain with pull-up
    sbrp_cfg_t  cfg;
    logic [1:0] mode;
    logic       valid, a;
    logic [7:0] q;
    int         errors = 0;
    int         n_checks = 0;
    always #12.5 i_clk = ~i_clk;
    sbrp_top #(.SLAVE_ADDR(ADDR)) DUT (.i_clk(i_clk), .i_rst(i_rst), .i_scl(scl), .i_sda(sda),
        .o_sda_o(sda_o), .o_sda_oe(oe), .i_mode_strap(strap), .o_cfg(cfg), .o_pll_mode(mode),
        .o_strap_valid(valid));
    sbrp_host host (.i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_pull(pull));
    // compare and count
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: %h not %h", $time, seen, exp);
        end
    endtask
    task automatic tally_and_finish();
        if (errors == 0 && n_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // host byte out, device must pull the ack low
    task automatic wb(input logic [7:0] d);
        host.xfer(d, 1'b1, q, a);
        check({7'h0, a}, 8'h00);
    endtask
    // host byte in, compared to the expected value
    task automatic rb(input logic [7:0] exp, input logic last);
        host.xfer(8'hff, last, q, a);
        check(q, exp);
    endtask
    task automatic open_at(input logic [7:0] idx);
        host.start();
        wb({ADDR, 1'b0});
        wb(idx);
    endtask
    task automatic open_rd(input logic [7:0] idx);
        open_at(idx);
        host.start();
        wb({ADDR, 1'b1});
    endtask
    task automatic do_reset();
        i_rst <= 1'b1;
        repeat (6) @(posedge i_clk);
        i_rst <= 1'b0;
        repeat (12) @(posedge i_clk);
    endtask
    // reset values, then the strap pin moves after capture
    task automatic t_reset();
        check({5'h0, cfg}, {5'h0, RST_OVERRIDE, RST_SW_MODE});
        check({5'h0, valid, mode}, 8'h06);
        strap <= 2'h3;
    endtask
    // write byte zero with ones in read-only bits and reserved bits 5:4
    task automatic t_write();
        open_at(IDX_PLL_MODE_SELECT);
        wb(8'h01);
        wb(8'hfa);
        host.stop();
        check({5'h0, cfg}, 8'h05);
        check({6'h0, mode}, 8'h01);
    endtask
    // full read from index zero, byte zero holding the written values
    task automatic t_read();
        open_rd(IDX_PLL_MODE_SELECT);
        rb({3'h0, RST_READBACK_COUNT}, 1'b0);
        rb(8'h8b, 1'b0);
        for (int i = 1; i < 7; i++)
            rb(8'h00, 1'b0);
        rb(8'h08, 1'b1);
        host.stop();
    endtask
    // two-byte write across indices six and seven, then a shorter count
    task automatic t_count();
        open_at(8'h06);
        wb(8'h02);
        wb(8'h55);
        wb(8'h03);
        host.stop();
        open_rd(IDX_READBACK_COUNT);
        rb(8'h03, 1'b0);
        rb(8'h03, 1'b1);
        host.stop();
    endtask
    // foreign address gets no acknowledge
    task automatic t_refuse();
        host.start();
        host.xfer({ADDR ^ 7'h01, 1'b0}, 1'b1, q, a);
        check({7'h0, a}, 8'h01);
        host.stop();
    endtask
    // warm reset restores defaults and takes the new strap
    task automatic t_rereset();
        do_reset();
        check({5'h0, cfg}, {5'h0, RST_OVERRIDE, RST_SW_MODE});
        check({6'h0, mode}, 8'h03);
    endtask
    initial begin
        do_reset();
        t_reset();
        t_write();
        t_read();
        t_count();
        t_refuse();
        t_rereset();
        tally_and_finish();
    end
    // watchdog
    initial begin
        #1_000_000;
        errors++;
        tally_and_finish();
    end
endmodule // test_smbus_block_register_port
